// ### include/cco_defs.svh
// cco_defs.svh: constants for the configuration clock oscillator block
// assumes a 50 MHz system clock feeding the frequency synthesis
`ifndef CCO_DEFS_SVH
`define CCO_DEFS_SVH

`define CCO_SYS_CLK_KHZ      50000
`define CCO_CODE_W           5
`define CCO_NUM_CODES        17
// frequency table index codes for the two default rates and the two user-only rates
`define CCO_CODE_2P5         5'h00
`define CCO_CODE_3P1         5'h01
`define CCO_CODE_80          5'h0F
`define CCO_CODE_163         5'h10
// power-up defaults
`define CCO_DEFAULT_OSC_CODE  `CCO_CODE_2P5
`define CCO_DEFAULT_CFG_CODE  `CCO_CODE_3P1
// phase accumulator width for the numerically controlled oscillator
`define CCO_ACC_W            32

`endif

// ### include/cco_pkg.sv
// cco_pkg.sv: types for the configuration clock oscillator block
// assumes cco_defs.svh is included by the users of these types
package cco_pkg;
  typedef logic [4:0] cco_code_t;
  typedef enum logic [1:0] {CCO_POWERUP, CCO_CONFIG, CCO_USER} cco_phase_e;
endpackage

// ### hw/cco_nco.sv
// cco_nco.sv: phase accumulator that makes a square clock from a step
// assumes the step only changes at a full period boundary (top level ensures it)
`timescale 1ns/1ps
`include "cco_defs.svh"

module cco_nco #(
  parameter int ACC_W = `CCO_ACC_W
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // step control
  input  wire logic [ACC_W-1:0] step_i,
  // generated clock and boundary pulse
  output logic                  clk_o,
  output logic                  wrap_o
);

  logic [ACC_W-1:0] acc_ff;
  logic [ACC_W:0]   sum;

  assign sum = {1'b0, acc_ff} + {1'b0, step_i};

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      acc_ff <= '0;
    else
      acc_ff <= sum[ACC_W-1:0];
  end

  // high half then low half; the carry marks the end of a whole period
  assign clk_o  = ~acc_ff[ACC_W-1];
  assign wrap_o = sum[ACC_W];

endmodule

// ### hw/cco_top.sv
// cco_top.sv: free-running oscillator and configuration master clock
// assumes the configuration loader presents the frequency code on the same clock
`timescale 1ns/1ps
`include "cco_defs.svh"

module cco_top #(
  parameter int ACC_W = `CCO_ACC_W
) (
  // clock and reset
  input  wire logic                    CLK_I,
  input  wire logic                    NRST_I,
  // frequency code from the configuration loader
  input  wire logic [`CCO_CODE_W-1:0]  FREQ_CODE_I,
  input  wire logic                    FREQ_CODE_VALID_I,
  input  wire logic                    CLK_BITS_DONE_I,
  input  wire logic                    CONFIG_DONE_I,
  // user routing of the oscillator into the clock tree
  input  wire logic                    USER_ROUTE_EN_I,
  // clocks and status
  output logic                         CONFIG_MASTER_CLOCK_O,
  output logic                         OSC_CLK_O,
  output logic                         USER_CLK_O,
  output logic [`CCO_CODE_W-1:0]       CFG_CODE_O,
  output logic [`CCO_CODE_W-1:0]       OSC_CODE_O,
  output logic                         CODE_REJECT_O
);

  ////////////////////////////////////////////////////////////////////////////
  // rate table

  // step = f_out * 2^ACC_W / f_sys, worked in kHz to stay exact enough
  function automatic logic [ACC_W-1:0] code_step(input cco_pkg::cco_code_t code);
    logic [31:0] khz;
    logic [63:0] num;
    khz = 32'd0;
    num = 64'd0;
    case (code)
      5'h00:   khz = 32'd2500;
      5'h01:   khz = 32'd3100;
      5'h02:   khz = 32'd4300;
      5'h03:   khz = 32'd5400;
      5'h04:   khz = 32'd6900;
      5'h05:   khz = 32'd8100;
      5'h06:   khz = 32'd9200;
      5'h07:   khz = 32'd10000;
      5'h08:   khz = 32'd13000;
      5'h09:   khz = 32'd15000;
      5'h0A:   khz = 32'd20000;
      5'h0B:   khz = 32'd26000;
      5'h0C:   khz = 32'd32000;
      5'h0D:   khz = 32'd40000;
      5'h0E:   khz = 32'd54000;
      5'h0F:   khz = 32'd80000;
      5'h10:   khz = 32'd163000;
      default: khz = 32'd2500;
    endcase
    num = ({32'd0, khz} << ACC_W) / 64'(`CCO_SYS_CLK_KHZ);
    return num[ACC_W-1:0];
  endfunction

  function automatic logic code_valid(input cco_pkg::cco_code_t code);
    return code < 5'(`CCO_NUM_CODES);
  endfunction

  function automatic logic code_cfg_ok(input cco_pkg::cco_code_t code);
    return code_valid(code) && code != `CCO_CODE_80 && code != `CCO_CODE_163;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // lifecycle

  cco_pkg::cco_phase_e phase_ff;

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      phase_ff <= cco_pkg::CCO_POWERUP;
    else
    begin
      case (phase_ff)
        cco_pkg::CCO_POWERUP: phase_ff <= cco_pkg::CCO_CONFIG;
        cco_pkg::CCO_CONFIG:
          if (CONFIG_DONE_I)
            phase_ff <= cco_pkg::CCO_USER;
        cco_pkg::CCO_USER: phase_ff <= cco_pkg::CCO_USER;
        default: phase_ff <= cco_pkg::CCO_POWERUP;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // code capture

  cco_pkg::cco_code_t pend_cfg_ff;
  cco_pkg::cco_code_t pend_osc_ff;
  logic               pend_ff;
  logic               reject_ff;
  logic               take;

  // codes are accepted only during configuration, so user mode keeps them
  assign take = FREQ_CODE_VALID_I && phase_ff == cco_pkg::CCO_CONFIG;

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      pend_cfg_ff <= `CCO_DEFAULT_CFG_CODE;
      pend_osc_ff <= `CCO_DEFAULT_OSC_CODE;
      reject_ff   <= 1'b0;
    end
    else if (take)
    begin
      if (code_valid(FREQ_CODE_I))
        pend_osc_ff <= FREQ_CODE_I;
      if (code_cfg_ok(FREQ_CODE_I))
        pend_cfg_ff <= FREQ_CODE_I;
      reject_ff <= !code_cfg_ok(FREQ_CODE_I);
    end
  end

  // pending request armed once the clock bits are in
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      pend_ff <= 1'b0;
    else if (CLK_BITS_DONE_I && phase_ff == cco_pkg::CCO_CONFIG)
      pend_ff <= 1'b1;
    else if (take)
      pend_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillators

  cco_pkg::cco_code_t cfg_code_ff;
  cco_pkg::cco_code_t osc_code_ff;
  logic               cfg_clk;
  logic               cfg_wrap;
  logic               osc_clk;
  logic               osc_wrap;

  // switch only on a period boundary so no pulse is cut short
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      cfg_code_ff <= `CCO_DEFAULT_CFG_CODE;
    else if (pend_ff && cfg_wrap)
      cfg_code_ff <= pend_cfg_ff;
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      osc_code_ff <= `CCO_DEFAULT_OSC_CODE;
    else if (pend_ff && osc_wrap)
      osc_code_ff <= pend_osc_ff;
  end

  // both never stop, independent of the lifecycle phase
  cco_nco #(.ACC_W(ACC_W)) u_osc (
    .clk_i  (CLK_I),
    .nrst_i (NRST_I),
    .step_i (code_step(osc_code_ff)),
    .clk_o  (osc_clk),
    .wrap_o (osc_wrap)
  );

  cco_nco #(.ACC_W(ACC_W)) u_cfg (
    .clk_i  (CLK_I),
    .nrst_i (NRST_I),
    .step_i (code_step(cfg_code_ff)),
    .clk_o  (cfg_clk),
    .wrap_o (cfg_wrap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign CONFIG_MASTER_CLOCK_O = cfg_clk;
  assign OSC_CLK_O             = osc_clk;
  // gated combinationally by the raw enable level, only in user mode; enable change may clip one pulse
  assign USER_CLK_O            = osc_clk & USER_ROUTE_EN_I
                                 & (phase_ff == cco_pkg::CCO_USER);
  assign CFG_CODE_O            = cfg_code_ff;
  assign OSC_CODE_O            = osc_code_ff;
  assign CODE_REJECT_O         = reject_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_cfg_never_user_only;
    @(posedge CLK_I) disable iff (!NRST_I)
    cfg_code_ff != `CCO_CODE_80 && cfg_code_ff != `CCO_CODE_163;
  endproperty
  a_cfg_never_user_only: assert property (p_cfg_never_user_only)
    else $error("config clock holds a user-only rate");

  property p_reject_flag;
    @(posedge CLK_I) disable iff (!NRST_I)
    take && !code_cfg_ok(FREQ_CODE_I) |=> CODE_REJECT_O;
  endproperty
  a_reject_flag: assert property (p_reject_flag)
    else $error("invalid config rate not flagged");

  property p_change_on_boundary;
    @(posedge CLK_I) disable iff (!NRST_I)
    !$stable(cfg_code_ff) |-> $past(cfg_wrap) && $past(pend_ff);
  endproperty
  a_change_on_boundary: assert property (p_change_on_boundary)
    else $error("config rate changed mid period");

  property p_osc_change_on_boundary;
    @(posedge CLK_I) disable iff (!NRST_I)
    !$stable(osc_code_ff) |-> $past(osc_wrap) && $past(pend_ff);
  endproperty
  a_osc_change_on_boundary: assert property (p_osc_change_on_boundary)
    else $error("oscillator rate changed mid period");

  property p_no_change_before_bits;
    @(posedge CLK_I) disable iff (!NRST_I)
    !pend_ff |=> $stable(cfg_code_ff);
  endproperty
  a_no_change_before_bits: assert property (p_no_change_before_bits)
    else $error("rate changed before clock bits received");

  sequence s_user_mode;
    phase_ff == cco_pkg::CCO_USER;
  endsequence

  property p_user_holds_code;
    @(posedge CLK_I) disable iff (!NRST_I)
    s_user_mode ##1 s_user_mode |-> $stable(pend_cfg_ff) && $stable(pend_osc_ff);
  endproperty
  a_user_holds_code: assert property (p_user_holds_code)
    else $error("code changed in user mode");

  // one spare cycle: the truncated step stretches the slowest period to 21 cycles
  property p_cfg_clock_runs;
    @(posedge CLK_I) disable iff (!NRST_I)
    cfg_wrap |-> ##[1:21] cfg_wrap;
  endproperty
  a_cfg_clock_runs: assert property (p_cfg_clock_runs)
    else $error("config clock stalled");

  property p_user_route;
    @(posedge CLK_I) disable iff (!NRST_I)
    phase_ff == cco_pkg::CCO_USER && USER_ROUTE_EN_I |-> USER_CLK_O == OSC_CLK_O;
  endproperty
  a_user_route: assert property (p_user_route)
    else $error("user clock not following oscillator");

endmodule

// ### sim/cco_top_test.sv
// cco_top_test.sv: self-checking bench for the configuration clock oscillator
// assumes cco_defs.svh on the include path and cco_top compiled before it
`timescale 1ns/1ps
`include "cco_defs.svh"

module cco_top_test;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [4:0] code = '0;
  logic       vld = 1'b0;
  logic       bits = 1'b0;
  logic       done = 1'b0;
  logic       ren = 1'b0;
  logic       cmc, osc, ucl, rej;
  logic [4:0] cfg, oco;
  logic [4:0] ecfg, eosc;
  logic       erej;
  int         fails = 0;
  int         total_checks = 0;
  int         r_osc, r_cmc;

  always #10 clk = ~clk;
  always @(posedge osc) r_osc++;
  always @(posedge cmc) r_cmc++;

  cco_top u_dut (.CLK_I(clk), .NRST_I(rst_n), .FREQ_CODE_I(code),
    .FREQ_CODE_VALID_I(vld), .CLK_BITS_DONE_I(bits), .CONFIG_DONE_I(done),
    .USER_ROUTE_EN_I(ren), .CONFIG_MASTER_CLOCK_O(cmc), .OSC_CLK_O(osc),
    .USER_CLK_O(ucl), .CFG_CODE_O(cfg), .OSC_CODE_O(oco), .CODE_REJECT_O(rej));

  ////////////////////////////////////////////////////////////////////////////
  function automatic int khz(input logic [4:0] c);
    int t[17] = '{2500, 3100, 4300, 5400, 6900, 8100, 9200, 10000, 13000,
                  15000, 20000, 26000, 32000, 40000, 54000, 80000, 163000};
    return t[c];
  endfunction

  task automatic give_verdict();
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [4:0] e, input logic [4:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("FAIL %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // nco jitter allows a couple of edges either way in the window
  task automatic near(input string n, input logic [4:0] c, input int g);
    int e;
    e = 500 * khz(c) / 50000;
    total_checks++;
    if (g < e - 2 || g > e + 2)
    begin
      fails++;
      $display("FAIL %s expected %0d seen %0d", n, e, g);
    end
  endtask

  // rates above 25 MHz alias on a 50 MHz nco, so only slower ones are timed
  task automatic rates();
    r_osc = 0;
    r_cmc = 0;
    repeat (500) @(negedge clk);
    if (khz(eosc) <= 25000)
      near("osc_rate", eosc, r_osc);
    if (khz(ecfg) <= 25000)
      near("cfg_rate", ecfg, r_cmc);
  endtask

  task automatic reset_state();
    chk("cfg_code", `CCO_DEFAULT_CFG_CODE, cfg);
    chk("osc_code", `CCO_DEFAULT_OSC_CODE, oco);
    chk("reject", 5'h0, {4'h0, rej});
    chk("user_clk", 5'h0, {4'h0, ucl});
  endtask

  task automatic send(input logic [4:0] c);
    @(posedge clk);
    code <= c;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    code <= 5'($urandom);
    @(negedge clk);
  endtask

  task automatic arm();
    @(posedge clk);
    bits <= 1'b1;
    @(posedge clk);
    bits <= 1'b0;
    @(negedge clk);
  endtask

  task automatic run(input logic [4:0] c);
    logic [4:0] ec, eo;
    int n;
    ec = (c < 5'h0F) ? c : ecfg;
    eo = (c <= 5'h10) ? c : eosc;
    send(c);
    chk("reject", {4'h0, c >= 5'h0F}, {4'h0, rej});
    erej = c >= 5'h0F;
    repeat (30) @(negedge clk);
    chk("cfg_hold", ecfg, cfg);
    arm();
    n = 0;
    while ((cfg !== ec || oco !== eo) && n < 120)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 120)
    begin
      fails++;
      $display("FAIL cfg_switch expected %0h seen %0h", ec, cfg);
      give_verdict();
    end
    chk("cfg_code", ec, cfg);
    chk("osc_code", eo, oco);
    ecfg = ec;
    eosc = eo;
    rates();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h15a3_015c));
    ecfg = `CCO_DEFAULT_CFG_CODE;
    eosc = `CCO_DEFAULT_OSC_CODE;
    erej = 1'b0;
    repeat (11) @(posedge clk);
    @(negedge clk);
    reset_state();
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rates();
    for (int c = 0; c < 17; c++)
      run(5'(c));
    run(5'h1F);
    repeat (8) run(5'($urandom_range(0, 31)));
    @(posedge clk);
    done <= 1'b1;
    ren <= 1'b1;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 100; i++)
    begin
      @(negedge clk);
      chk("user_clk", {4'h0, osc}, {4'h0, ucl});
    end
    send(ecfg == 5'h07 ? 5'h08 : 5'h07);
    chk("reject_kept", {4'h0, erej}, {4'h0, rej});
    arm();
    repeat (100) @(negedge clk);
    chk("cfg_kept", ecfg, cfg);
    chk("osc_kept", eosc, oco);
    rates();
    @(posedge clk);
    ren <= 1'b0;
    // long enough to span a whole high half of the slowest oscillator rate
    for (int i = 0; i < 40; i++)
    begin
      @(negedge clk);
      chk("user_off", 5'h0, {4'h0, ucl});
    end
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(negedge clk);
    reset_state();
    give_verdict();
  end
endmodule
